// ===== seq_cfg.svh
/*
  Constants of the event/action sequencer: register indices, field
  positions, reset values and table sizes.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH

`define SEQ_MAX_PAIRS 20
`define SEQ_NUM_CMP 4
`define SEQ_NUM_RULE 4
`define SEQ_VAR_W 16
`define SEQ_SEL_W 5
`define SEQ_ACT_W 8
`define SEQ_ADDR_W 6
`define SEQ_DATA_W 32

`define SEQ_REG_CTRL 6'h00
`define SEQ_REG_COUNT 6'h01
`define SEQ_REG_STATUS 6'h02
`define SEQ_REG_CMP_BASE 6'h04
`define SEQ_REG_RULE_BASE 6'h08
`define SEQ_REG_PAIR_BASE 6'h10

`define SEQ_CTRL_RUN_BIT 0
`define SEQ_STATUS_RUN_BIT 8
`define SEQ_STATUS_ACT_LSB 16
`define SEQ_COUNT_RST 5'h01

`define SEQ_SRC_STATUS 0
`define SEQ_SRC_DIN 8
`define SEQ_SRC_TIMER 12
`define SEQ_SRC_CMP 16
`define SEQ_SRC_RULE 20
`define SEQ_SRC_TRUE 24

`endif

// ===== seq_pkg.sv
/*
  Types shared by the sequencer modules: states, operator codes and
  the packed layouts of comparator, logic rule and pair registers.
  Assumes seq_cfg.svh is on the include path.
*/
`include "seq_cfg.svh"

package seq_pkg;

  typedef enum logic {st_idle, st_run} seq_state_t;

  typedef enum logic [1:0] {cmp_gt, cmp_lt, cmp_eq, cmp_ne} cmp_op_t;

  typedef enum logic [1:0] {lop_and, lop_or, lop_and_not, lop_or_not}
    rule_op_t;

  typedef struct packed {
    cmp_op_t op;
    logic [1:0] var_sel;
    logic [`SEQ_VAR_W-1:0] preset;
  } cmp_cfg_t;

  typedef struct packed {
    rule_op_t op2;
    rule_op_t op1;
    logic [2:0] invert;
    logic [`SEQ_SEL_W-1:0] sel2;
    logic [`SEQ_SEL_W-1:0] sel1;
    logic [`SEQ_SEL_W-1:0] sel0;
  } rule_cfg_t;

  typedef struct packed {
    logic [`SEQ_ACT_W-1:0] action_select;
    logic [`SEQ_SEL_W-1:0] event_condition_select;
  } pair_t;

  function automatic logic bit_of(input logic [31:0] vec,
                                  input logic [`SEQ_SEL_W-1:0] sel);
    return vec[sel];
  endfunction : bit_of

endpackage : seq_pkg

// ===== seq_cond_if.sv
/*
  Carrier between the sequencer core and its comparator and logic rule
  banks. Assumes the core drives the configuration and source signals.
*/
`timescale 1ns/1ps
`default_nettype none
`include "seq_cfg.svh"

interface seq_cond_if;
  import seq_pkg::*;

  logic [`SEQ_NUM_CMP-1:0][`SEQ_VAR_W-1:0] vars;
  cmp_cfg_t [`SEQ_NUM_CMP-1:0] cmp_cfg;
  logic [`SEQ_NUM_CMP-1:0] comp;
  logic [31:0] src;
  rule_cfg_t [`SEQ_NUM_RULE-1:0] rule_cfg;
  logic [`SEQ_NUM_RULE-1:0] rule;

  modport cmp_mp (input vars, input cmp_cfg, output comp);
  modport rule_mp (input src, input rule_cfg, output rule);
endinterface : seq_cond_if

`default_nettype wire

// ===== seq_compare_bank.sv
/*
  Bank of comparators: each checks one selected drive variable against
  its preset. Assumes variables are stable on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "seq_cfg.svh"

module seq_compare_bank
  import seq_pkg::*;
(
  seq_cond_if.cmp_mp bus
);

  function automatic logic cmp_eval(input cmp_op_t op,
                                    input logic [`SEQ_VAR_W-1:0] a,
                                    input logic [`SEQ_VAR_W-1:0] b);
    logic r;
    r = 1'b0;
    unique case (op)
      cmp_gt: r = a > b;
      cmp_lt: r = a < b;
      cmp_eq: r = a == b;
      cmp_ne: r = a != b;
    endcase
    return r;
  endfunction : cmp_eval

  genvar i;
  generate
    for (i = 0; i < `SEQ_NUM_CMP; i++)
    begin : g_cmp
      // unsigned compare; signed variables must be offset upstream
      assign bus.comp[i] = cmp_eval(bus.cmp_cfg[i].op,
                                    bus.vars[bus.cmp_cfg[i].var_sel],
                                    bus.cmp_cfg[i].preset);
    end
  endgenerate

endmodule : seq_compare_bank

`default_nettype wire

// ===== seq_rule_bank.sv
/*
  Bank of logic rules: each combines three selected boolean sources.
  Assumes the source vector holds no rule outputs, so no loop exists.
*/
`timescale 1ns/1ps
`default_nettype none
`include "seq_cfg.svh"

module seq_rule_bank
  import seq_pkg::*;
(
  seq_cond_if.rule_mp bus
);

  function automatic logic lop(input rule_op_t op, input logic x,
                               input logic y);
    logic r;
    r = 1'b0;
    unique case (op)
      lop_and: r = x & y;
      lop_or: r = x | y;
      lop_and_not: r = x & ~y;
      lop_or_not: r = x | ~y;
    endcase
    return r;
  endfunction : lop

  function automatic logic rule_eval(input rule_cfg_t c,
                                     input logic [31:0] v);
    logic a;
    logic b;
    logic d;
    a = bit_of(v, c.sel0) ^ c.invert[0];
    b = bit_of(v, c.sel1) ^ c.invert[1];
    d = bit_of(v, c.sel2) ^ c.invert[2];
    return lop(c.op2, lop(c.op1, a, b), d);
  endfunction : rule_eval

  genvar i;
  generate
    for (i = 0; i < `SEQ_NUM_RULE; i++)
    begin : g_rule
      // a two-input rule selects the constant-true source as its third
      assign bus.rule[i] = rule_eval(bus.rule_cfg[i], bus.src);
    end
  endgenerate

endmodule : seq_rule_bank

`default_nettype wire

// ===== event_action_sequencer.sv
/*
  Event/action sequencer core with its register port, comparator bank
  and logic rule bank. Assumes status, timer and variable inputs come
  from logic on clock_i, digital inputs from pins, and a one-cycle
  scan tick marks each scan interval.
*/
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "seq_cfg.svh"

// Overview of operation
// - numbered pairs link one event selection to one action selection.
// - an event is a status bit, logic rule or comparator being true.
// - true current event fires its action, then the next event is used.
// - only one event is evaluated at any time.
// - false event: no action, no other event, position kept.
// - after start only event zero is checked each scan until true.
// - one to twenty pairs may be programmed.
// - after the last pair's action, evaluation returns to event zero.
// - comparators test a selected variable against a fixed preset.
// - logic rules join up to three booleans with AND, OR and NOT.
// - rule and comparator outputs are visible to other functions.
module event_action_sequencer
  import seq_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [`SEQ_ADDR_W-1:0] addr_i,
  input wire logic [`SEQ_DATA_W-1:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [`SEQ_DATA_W-1:0] rdata_o,
  input wire logic scan_tick_i,
  input wire logic [7:0] status_i,
  input wire logic [3:0] din_i,
  input wire logic [3:0] timer_i,
  input wire logic [`SEQ_NUM_CMP*`SEQ_VAR_W-1:0] vars_i,
  output logic action_valid_o,
  output logic [`SEQ_ACT_W-1:0] action_code_o,
  output logic [`SEQ_SEL_W-1:0] pair_index_o,
  output logic running_o,
  output logic [`SEQ_NUM_CMP-1:0] compare_o,
  output logic [`SEQ_NUM_RULE-1:0] rule_o
);

  logic [3:0] din_meta;
  logic [3:0] din_sync;
  logic run_ctl;
  logic [`SEQ_SEL_W-1:0] pair_count;
  cmp_cfg_t [`SEQ_NUM_CMP-1:0] cmp_cfg;
  rule_cfg_t [`SEQ_NUM_RULE-1:0] rule_cfg;
  pair_t pair_tab [`SEQ_MAX_PAIRS];
  seq_state_t state;
  logic [`SEQ_SEL_W-1:0] index;
  logic [`SEQ_ACT_W-1:0] last_action;
  logic [`SEQ_SEL_W-1:0] last_pair;
  logic [31:0] bool_vec;
  logic [31:0] src_vec;
  pair_t cur_pair;
  logic event_true;
  logic fire;
  logic [`SEQ_DATA_W-1:0] read_mux;
  logic [`SEQ_ADDR_W-1:0] rel_addr;

  seq_cond_if cond ();

  seq_compare_bank u_cmp (
    .bus(cond.cmp_mp)
  );

  seq_rule_bank u_rule (
    .bus(cond.rule_mp)
  );

  // digital inputs come from pins; only din_sync is read by logic
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      din_meta <= 4'h0;
      din_sync <= 4'h0;
    end
    else
    begin
      din_meta <= din_i;
      din_sync <= din_meta;
    end
  end

  assign cond.vars = vars_i;
  assign cond.cmp_cfg = cmp_cfg;
  assign cond.rule_cfg = rule_cfg;
  // rules see no rule outputs, which keeps the rule bank loop free
  assign src_vec = {7'h00, 1'b1, 4'h0, cond.comp, timer_i, din_sync,
                    status_i};
  assign cond.src = src_vec;
  assign bool_vec = {7'h00, 1'b1, cond.rule, cond.comp, timer_i,
                     din_sync, status_i};

  // out-of-range counts are clamped rather than refused
  always_comb
  begin
    if (pair_count == 5'h00)
      last_pair = 5'h00;
    else if (pair_count > 5'(`SEQ_MAX_PAIRS))
      last_pair = 5'(`SEQ_MAX_PAIRS - 1);
    else
      last_pair = pair_count - 5'h01;
  end

  assign cur_pair = pair_tab[index];
  assign event_true = bit_of(bool_vec, cur_pair.event_condition_select);
  assign fire = scan_tick_i && (state == st_run) && run_ctl &&
                event_true;

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      run_ctl <= 1'b0;
      pair_count <= `SEQ_COUNT_RST;
    end
    else if (write_i)
    begin
      if (addr_i == `SEQ_REG_CTRL)
        run_ctl <= wdata_i[`SEQ_CTRL_RUN_BIT];
      if (addr_i == `SEQ_REG_COUNT)
        pair_count <= wdata_i[`SEQ_SEL_W-1:0];
    end
  end

  genvar i;
  generate
    for (i = 0; i < `SEQ_NUM_CMP; i++)
    begin : g_cmp_reg
      always_ff @(posedge clock_i)
      begin
        if (!resetn_i)
          cmp_cfg[i] <= '0;
        else if (write_i && addr_i == 6'(`SEQ_REG_CMP_BASE + i))
          cmp_cfg[i] <= cmp_cfg_t'(wdata_i[$bits(cmp_cfg_t)-1:0]);
      end
    end
    for (i = 0; i < `SEQ_NUM_RULE; i++)
    begin : g_rule_reg
      always_ff @(posedge clock_i)
      begin
        if (!resetn_i)
          rule_cfg[i] <= '0;
        else if (write_i && addr_i == 6'(`SEQ_REG_RULE_BASE + i))
          rule_cfg[i] <= rule_cfg_t'(wdata_i[$bits(rule_cfg_t)-1:0]);
      end
    end
    for (i = 0; i < `SEQ_MAX_PAIRS; i++)
    begin : g_pair_reg
      always_ff @(posedge clock_i)
      begin
        if (!resetn_i)
          pair_tab[i] <= '0;
        else if (write_i && addr_i == 6'(`SEQ_REG_PAIR_BASE + i))
          pair_tab[i] <= pair_t'(wdata_i[$bits(pair_t)-1:0]);
      end
    end
  endgenerate

  // a count lowered below the index while running wraps on next fire
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      state <= st_idle;
      index <= 5'h00;
      running_o <= 1'b0;
    end
    else
    begin
      unique case (state)
        st_idle:
        begin
          index <= 5'h00;
          if (run_ctl)
          begin
            state <= st_run;
            running_o <= 1'b1;
          end
        end
        st_run:
        begin
          if (!run_ctl)
          begin
            state <= st_idle;
            running_o <= 1'b0;
            index <= 5'h00;
          end
          else if (fire)
          begin
            if (index >= last_pair)
              index <= 5'h00;
            else
              index <= index + 5'h01;
          end
        end
      endcase
    end
  end

  assign pair_index_o = index;

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      action_valid_o <= 1'b0;
      action_code_o <= 8'h00;
      last_action <= 8'h00;
    end
    else
    begin
      action_valid_o <= fire;
      if (fire)
      begin
        action_code_o <= cur_pair.action_select;
        last_action <= cur_pair.action_select;
      end
    end
  end

  // registered copies so other drive functions can use them freely
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      compare_o <= 4'h0;
      rule_o <= 4'h0;
    end
    else
    begin
      compare_o <= cond.comp;
      rule_o <= cond.rule;
    end
  end

  assign rel_addr = addr_i - `SEQ_REG_PAIR_BASE;

  always_comb
  begin
    read_mux = 32'h0000_0000;
    if (addr_i == `SEQ_REG_CTRL)
      read_mux = {31'h0000_0000, run_ctl};
    else if (addr_i == `SEQ_REG_COUNT)
      read_mux = {27'h000_0000, pair_count};
    else if (addr_i == `SEQ_REG_STATUS)
      read_mux = {8'h00, last_action, 7'h00, running_o, 3'h0, index};
    else if (addr_i >= `SEQ_REG_CMP_BASE &&
             addr_i < `SEQ_REG_CMP_BASE + 6'h04)
      read_mux = 32'(cmp_cfg[addr_i[1:0]]);
    else if (addr_i >= `SEQ_REG_RULE_BASE &&
             addr_i < `SEQ_REG_RULE_BASE + 6'h04)
      read_mux = 32'(rule_cfg[addr_i[1:0]]);
    else if (addr_i >= `SEQ_REG_PAIR_BASE &&
             rel_addr < 6'(`SEQ_MAX_PAIRS))
      read_mux = 32'(pair_tab[rel_addr[4:0]]);
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      rdata_o <= 32'h0000_0000;
    else if (read_i)
      rdata_o <= read_mux;
    else
      rdata_o <= 32'h0000_0000;
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  AST_FIRE_NEEDS_TRUE: assert property (
    action_valid_o |-> $past(scan_tick_i) && $past(event_true) &&
                       $past(running_o))
    else $error("action issued without a true event on a scan tick");

  AST_FALSE_HOLDS: assert property (
    (scan_tick_i && running_o && run_ctl && !event_true) |=>
      (!action_valid_o && $stable(index)))
    else $error("false event changed position or issued an action");

  AST_ADVANCE: assert property (
    (fire && index < last_pair) |=> (index == $past(index) + 5'h01))
    else $error("index did not step after a fired action");

  AST_WRAP: assert property (
    (fire && index >= last_pair) |=> (index == 5'h00))
    else $error("index did not wrap after the last pair");

  AST_STOP_CLEARS: assert property (
    (!run_ctl) |=> ##1 (index == 5'h00 && !action_valid_o))
    else $error("stopped sequencer kept its index or issued action");

  AST_START_AT_ZERO: assert property (
    $rose(running_o) |-> (index == 5'h00))
    else $error("sequence did not start at event zero");

  AST_ACTION_CODE: assert property (
    fire |=> (action_valid_o &&
              action_code_o == $past(cur_pair.action_select)))
    else $error("action code does not match the current pair");

  AST_INDEX_RANGE: assert property (
    index < 5'(`SEQ_MAX_PAIRS))
    else $error("pair index beyond the largest table entry");

  AST_PULSE_PER_TICK: assert property (
    (action_valid_o && !$past(scan_tick_i, 1)) |-> 1'b0)
    else $error("action pulse without a scan tick before it");

  AST_OUTPUTS_LIVE: assert property (
    (compare_o == $past(cond.comp)) && (rule_o == $past(cond.rule)))
    else $error("comparator or rule outputs not forwarded");

  COV_FIRE: cover property (fire);
  COV_WRAP: cover property (fire && index == last_pair &&
                            last_pair != 5'h00);
  COV_WAIT: cover property (scan_tick_i && running_o && !event_true);
  COV_STOP: cover property ($fell(running_o));

endmodule : event_action_sequencer

`default_nettype wire

// ===== drive_model.sv
/*
  Drive side model: status bits, digital input pins, timer outputs and
  the four live variables seen by the sequencer.
  Assumes the bench supplies wanted values; they appear one edge later,
  as from real status logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module drive_model
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [15:0] want_i,
  input wire logic [63:0] vwant_i,
  output logic [7:0] status_o,
  output logic [3:0] din_o,
  output logic [3:0] timer_o,
  output logic [63:0] vars_o
);
  // sources are laid out as the sequencer numbers them: 0-7, 8-11, 12-15
  always_ff @(posedge clock_i)
  begin
    status_o <= resetn_i ? want_i[7:0] : 8'h00;
    din_o <= resetn_i ? want_i[11:8] : 4'h0;
    timer_o <= resetn_i ? want_i[15:12] : 4'h0;
    vars_o <= resetn_i ? vwant_i : 64'h0;
  end
endmodule : drive_model

`default_nettype wire

// ===== event_action_sequencer_tb.sv
/*
  Self-checking bench of the event/action sequencer.
  Assumes the drive model feeds status, pins, timers and variables.
*/
`timescale 1ns/1ps
`default_nettype none
`include "seq_cfg.svh"

module event_action_sequencer_tb;
  import seq_pkg::*;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [`SEQ_ADDR_W-1:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rd;
  logic [31:0] seed = 32'd42363;
  logic [15:0] want = 16'h0;
  logic [63:0] vwant = 64'h0;
  logic [63:0] vars;
  logic write = 1'b0;
  logic read = 1'b0;
  logic tick = 1'b0;
  logic [7:0] status;
  logic [3:0] din, timer, cmp, rul;
  logic act_v, run;
  logic [7:0] act_c;
  logic [4:0] idx;
  logic [7:0] code [3];
  logic [15:0] pre [4];
  logic [2:0] inv [4];
  logic a, b, c;
  int err_total = 0;
  int n_compared = 0;
  int n_act = 0;
  int exp_act = 0;

  always #5 clock_i = ~clock_i;

  drive_model drv_u (.clock_i(clock_i), .resetn_i(resetn_i),
    .want_i(want), .vwant_i(vwant), .status_o(status), .din_o(din),
    .timer_o(timer), .vars_o(vars));

  event_action_sequencer dut_u (.clock_i(clock_i), .resetn_i(resetn_i),
    .addr_i(addr), .wdata_i(wdata), .write_i(write), .read_i(read),
    .rdata_o(rd), .scan_tick_i(tick), .status_i(status), .din_i(din),
    .timer_i(timer), .vars_i(vars), .action_valid_o(act_v),
    .action_code_o(act_c), .pair_index_o(idx), .running_o(run),
    .compare_o(cmp), .rule_o(rul));

  // every pulse counts, so a stretched or stray pulse shows at the end
  always @(posedge clock_i)
    if (act_v === 1'b1)
      n_act++;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic cmp_exp(input logic [1:0] op,
                                   input logic [15:0] x, y);
    case (op)
      2'h0: return x > y;
      2'h1: return x < y;
      2'h2: return x == y;
      default: return x != y;
    endcase
  endfunction : cmp_exp

  function automatic logic lop(input logic [1:0] op, input logic x, y);
    case (op)
      2'h0: return x & y;
      2'h1: return x | y;
      2'h2: return x & ~y;
      default: return x | ~y;
    endcase
  endfunction : lop

  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : step

  task automatic wr(input logic [5:0] ad, input logic [31:0] d);
    @(posedge clock_i);
    addr <= ad;
    wdata <= d;
    write <= 1'b1;
    @(posedge clock_i);
    write <= 1'b0;
  endtask : wr

  task automatic rdc(input string n, input logic [5:0] ad,
                     input logic [31:0] e);
    @(posedge clock_i);
    addr <= ad;
    read <= 1'b1;
    @(posedge clock_i);
    read <= 1'b0;
    #1;
    chk(n, e, rd);
  endtask : rdc

  // tick and look at the answer in the one cycle it stands
  task automatic scan(input logic fire, input logic [7:0] cd,
                      input logic [4:0] ix);
    @(posedge clock_i);
    tick <= 1'b1;
    @(posedge clock_i);
    tick <= 1'b0;
    #1;
    chk("action_valid", fire, act_v);
    if (fire)
    begin
      exp_act++;
      chk("action_code", cd, act_c);
    end
    chk("pair_index", ix, idx);
  endtask : scan

  initial
  begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    print_verdict();
  end

  initial
  begin
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    rdc("ctrl", 6'h00, 32'h0);
    rdc("count", 6'h01, 32'h1);
    rdc("status", 6'h02, 32'h0);
    rdc("unmapped", 6'h03, 32'h0);
    // the count is stored as written; clamping happens where it is used
    wr(6'h01, 32'h0);
    rdc("count", 6'h01, 32'h0);
    wr(6'h01, 32'h1f);
    rdc("count", 6'h01, 32'h1f);
    wr(6'h01, 32'h3);
    for (int k = 0; k < 3; k++)
      code[k] = 8'(rnd());
    // event sources: status bit 0, pin 0 through its sync, constant true
    wr(6'h10, {19'h0, code[0], 5'd0});
    wr(6'h11, {19'h0, code[1], 5'd8});
    wr(6'h12, {19'h0, code[2], 5'd24});
    want <= 16'h0001;
    scan(1'b0, 8'h00, 5'd0);
    wr(6'h00, 32'h1);
    step(2);
    chk("running", 1'b1, run);
    want <= 16'h0000;
    step(3);
    scan(1'b0, 8'h00, 5'd0);
    scan(1'b0, 8'h00, 5'd0);
    scan(1'b0, 8'h00, 5'd0);
    want <= 16'h0001;
    step(3);
    scan(1'b1, code[0], 5'd1);
    scan(1'b0, 8'h00, 5'd1);
    want <= 16'h0101;
    step(5);
    scan(1'b1, code[1], 5'd2);
    scan(1'b1, code[2], 5'd0);
    scan(1'b1, code[0], 5'd1);
    rdc("status", 6'h02, {8'h0, code[0], 7'h0, 1'b1, 8'h01});
    rdc("pair", 6'h11, {19'h0, code[1], 5'd8});
    wr(6'h00, 32'h0);
    step(2);
    chk("running", 1'b0, run);
    chk("pair_index", 5'd0, idx);
    scan(1'b0, 8'h00, 5'd0);
    // comparators stay live while stopped, every op on its own variable
    for (int k = 0; k < 4; k++)
    begin
      pre[k] = 16'(rnd());
      wr(6'(6'h04 + k), {12'h0, k[1:0], k[1:0], pre[k]});
    end
    for (int i = 0; i < 20; i++)
    begin
      vwant <= (i == 0) ? {pre[3], pre[2], pre[1], pre[0]}
                        : {rnd(), rnd()};
      step(3);
      for (int k = 0; k < 4; k++)
      begin
        a = cmp_exp(2'(k), vars[16*k +: 16], pre[k]);
        chk("compare", a, cmp[k]);
      end
    end
    for (int k = 0; k < 4; k++)
    begin
      inv[k] = 3'(rnd());
      wr(6'(6'h08 + k), {10'h0, 2'(3 - k), k[1:0], inv[k], 5'd12, 5'd1,
                         5'd0});
    end
    for (int i = 0; i < 20; i++)
    begin
      want <= 16'(rnd());
      step(3);
      for (int k = 0; k < 4; k++)
      begin
        a = want[0] ^ inv[k][0];
        b = want[1] ^ inv[k][1];
        c = want[12] ^ inv[k][2];
        a = lop(2'(k), a, b);
        chk("rule", lop(2'(3 - k), a, c), rul[k]);
      end
    end
    chk("action pulses", exp_act, n_act);
    print_verdict();
  end
endmodule : event_action_sequencer_tb

`default_nettype wire
